// ### rtl/sbs_defs.vh
// constants for the burst sram cycle decode block
// What this block does
// - deselect on inactive selects with a strobe, except a processor strobe when primary select is the only inactive select
// - sleep input forces power down, bus off
// - processor strobe loads address, begins read
// - processor strobe cycle is always a read
// - writes only after processor strobe or controller
// - controller strobe loads address, write or read
// - advance low steps to next burst address
// - advance high repeats current burst address
// - burst write accepts data regardless of oe
// - write when global, or enable plus lane
// - oe registered on the clock, masked during write cycles
// - read drives bus only with oe low
// - each low lane select writes its lane
// - narrow variant has two lanes, same decode
// - global write low writes every lane
// - two-bit wrap counter, linear or interleaved
`ifndef SBS_DEFS_VH
`define SBS_DEFS_VH
`define SBS_CYC_DESEL   3'd0
`define SBS_CYC_SLEEP   3'd1
`define SBS_CYC_BEGIN   3'd2
`define SBS_CYC_NEXT    3'd3
`define SBS_CYC_SUSPEND 3'd4
`define SBS_CYC_IDLE    3'd5
`define SBS_LANES_WIDE  4
`define SBS_ADDR_W      20
`endif

// ### rtl/sbs_burst_counter.v
// two-bit wraparound burst address counter
`timescale 1ns/1ps
`default_nettype none
module sbs_burst_counter (
   input  wire       ref_clk,
   input  wire       arst_n,
   input  wire       load,
   input  wire       step,
   input  wire [1:0] start_bits,
   input  wire       interleave,
   output wire [1:0] burst_bits
);
   reg [1:0] base;
   reg [1:0] count;

   // load captures the first address, step advances the sequence
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         base  <= 2'h0;
         count <= 2'h0;
      end else if (load) begin
         base  <= start_bits;
         count <= 2'h0;
      end else if (step) begin
         count <= count + 2'h1;
      end
   end

   // interleaved order xors, linear order adds with wrap
   assign burst_bits = interleave ? (base ^ count) : (base + count);
endmodule // sbs_burst_counter
`default_nettype wire

// ### rtl/sbs_cycle_decode.v
// cycle decode and byte write control for a flow-through burst sram
`timescale 1ns/1ps
`default_nettype none
`include "sbs_defs.vh"
module sbs_cycle_decode #(
   parameter LANES  = `SBS_LANES_WIDE,
   parameter ADDR_W = `SBS_ADDR_W
) (
   input  wire              ref_clk,
   input  wire              arst_n,
   input  wire              primary_select_n,
   input  wire              expansion_select_hi,
   input  wire              expansion_select_n,
   input  wire              processor_addr_strobe_n,
   input  wire              controller_addr_strobe_n,
   input  wire              burst_advance_n,
   input  wire              global_write_n,
   input  wire              lane_write_enable_n,
   input  wire [LANES-1:0]  lane_select_n,
   input  wire              sleep_request,
   input  wire              burst_order,
   input  wire              output_enable_n,
   input  wire [ADDR_W-1:0] ext_addr,
   output reg  [ADDR_W-1:0] core_addr,
   output reg  [2:0]        cycle_kind,
   output reg               core_read,
   output reg  [LANES-1:0]  core_lane_write,
   output reg               data_capture,
   output reg               bus_drive_en,
   output reg               in_sleep
);
   wire       all_sel;
   wire       write_ind;
   wire       proc_go;
   wire       ctrl_go;
   wire       cont;
   wire [1:0] burst_bits;
   reg  [2:0] next_kind;
   reg        next_read;
   reg  [LANES-1:0] next_lanes;
   reg  [ADDR_W-1:2] hi_addr;
   reg        active;
   reg        rd_cycle;

   // selection and write indication
   assign all_sel   = !primary_select_n && expansion_select_hi && !expansion_select_n;
   assign write_ind = !global_write_n ||
                      (!lane_write_enable_n && !(&lane_select_n));
   // processor strobe is ignored while primary select is high
   assign proc_go   = all_sel && !processor_addr_strobe_n;
   assign ctrl_go   = all_sel && processor_addr_strobe_n && !controller_addr_strobe_n;
   assign cont      = !controller_addr_strobe_n ? 1'b0 :
                      (processor_addr_strobe_n || primary_select_n);

   // cycle selection, in priority order
   always @* begin
      next_kind = `SBS_CYC_IDLE;
      next_read = 1'b1;
      if (sleep_request)
         next_kind = `SBS_CYC_SLEEP;
      else if (proc_go) begin
         next_kind = `SBS_CYC_BEGIN;
         next_read = 1'b1;
      end else if (ctrl_go) begin
         next_kind = `SBS_CYC_BEGIN;
         next_read = !write_ind;
      end else if ((primary_select_n && !controller_addr_strobe_n) ||
                   ((!expansion_select_hi || expansion_select_n) &&
                    (!controller_addr_strobe_n || !processor_addr_strobe_n)))
         next_kind = `SBS_CYC_DESEL;
      else if (cont && active) begin
         next_kind = burst_advance_n ? `SBS_CYC_SUSPEND : `SBS_CYC_NEXT;
         next_read = !write_ind;
      end
   end

   // lane write decode, per lane
   genvar g;
   generate
      for (g = 0; g < LANES; g = g + 1) begin : g_lane
         always @* begin
            next_lanes[g] = !next_read && (!global_write_n ||
               (!lane_write_enable_n && !lane_select_n[g]));
         end
      end
   endgenerate

   sbs_burst_counter u_cnt (
      .ref_clk    (ref_clk),
      .arst_n     (arst_n),
      .load       (next_kind == `SBS_CYC_BEGIN),
      .step       (next_kind == `SBS_CYC_NEXT),
      .start_bits (ext_addr[1:0]),
      .interleave (burst_order),
      .burst_bits (burst_bits)
   );

   // registered cycle state
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         cycle_kind      <= `SBS_CYC_IDLE;
         core_read       <= 1'b1;
         core_lane_write <= {LANES{1'b0}};
         data_capture    <= 1'b0;
         active          <= 1'b0;
         rd_cycle        <= 1'b0;
         hi_addr         <= {(ADDR_W-2){1'b0}};
         in_sleep        <= 1'b0;
      end else begin
         cycle_kind      <= next_kind;
         core_read       <= next_read;
         core_lane_write <= next_lanes;
         data_capture    <= !next_read && (next_kind == `SBS_CYC_BEGIN ||
                            next_kind == `SBS_CYC_NEXT || next_kind == `SBS_CYC_SUSPEND);
         in_sleep        <= sleep_request;
         if (next_kind == `SBS_CYC_BEGIN) begin
            hi_addr <= ext_addr[ADDR_W-1:2];
            active  <= 1'b1;
         end else if (next_kind == `SBS_CYC_DESEL || next_kind == `SBS_CYC_SLEEP)
            active  <= 1'b0;
         rd_cycle <= next_read && (next_kind == `SBS_CYC_BEGIN ||
                     next_kind == `SBS_CYC_NEXT || next_kind == `SBS_CYC_SUSPEND);
      end
   end

   // address out follows the burst counter
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n)
         core_addr <= {ADDR_W{1'b0}};
      else
         core_addr <= {hi_addr, burst_bits};
   end

   // output enable, sampled at full clock rate; masked in writes and sleep
   always @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n)
         bus_drive_en <= 1'b0;
      else
         bus_drive_en <= rd_cycle && !output_enable_n && !sleep_request;
   end
endmodule // sbs_cycle_decode
`default_nettype wire

// ### bench/sbs_master_model.sv
// bus master stand-in that drives output enable
`timescale 1ns/1ps
`default_nettype none
module sbs_master_model (
   input  wire logic ref_clk,
   input  wire logic write_soon,
   output var  logic output_enable_n
);
   // park output enable high one edge ahead of any write
   initial output_enable_n = 1'b1;
   always @(posedge ref_clk) output_enable_n <= write_soon;
endmodule // sbs_master_model
`default_nettype wire

// ### bench/sbs_cycle_decode_properties.sv
// port assertions for the burst sram cycle decode
`timescale 1ns/1ps
`default_nettype none
module sbs_cycle_decode_checker #(
   parameter LANES  = 4,
   parameter ADDR_W = 20
) (
   input wire logic              ref_clk,
   input wire logic              arst_n,
   input wire logic              primary_select_n,
   input wire logic              expansion_select_hi,
   input wire logic              expansion_select_n,
   input wire logic              processor_addr_strobe_n,
   input wire logic              controller_addr_strobe_n,
   input wire logic              global_write_n,
   input wire logic              lane_write_enable_n,
   input wire logic [LANES-1:0]  lane_select_n,
   input wire logic              sleep_request,
   input wire logic              burst_order,
   input wire logic [ADDR_W-1:0] core_addr,
   input wire logic [2:0]        cycle_kind,
   input wire logic              core_read,
   input wire logic [LANES-1:0]  core_lane_write,
   input wire logic              data_capture,
   input wire logic              bus_drive_en,
   input wire logic              in_sleep
);
   // selection and burst qualifiers
   wire logic sel = !primary_select_n && expansion_select_hi && !expansion_select_n && !sleep_request;
   wire logic brst = cycle_kind == 3'd3 || cycle_kind == 3'd4;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   sequence s_proc;
      sel && !processor_addr_strobe_n;
   endsequence
   sequence s_ctrl_lane;
      sel && processor_addr_strobe_n && !controller_addr_strobe_n && global_write_n
         && !lane_write_enable_n;
   endsequence
   a_sleep_wins: assert property (sleep_request |=> cycle_kind == 3'd1 && in_sleep)
      else $error("sleep not entered");
   a_proc_read: assert property (s_proc |=> cycle_kind == 3'd2 && core_read && core_lane_write == 0)
      else $error("processor strobe not a read");
   a_ctrl_lanes: assert property (s_ctrl_lane |=> cycle_kind == 3'd2 && core_lane_write == ~$past(lane_select_n))
      else $error("lane decode wrong");
   a_desel_cycle: assert property (!sleep_request && primary_select_n && !controller_addr_strobe_n |=> cycle_kind == 3'd0 ##1 !bus_drive_en)
      else $error("deselect missed");
   a_global_all: assert property (brst && !$past(global_write_n) |-> &core_lane_write)
      else $error("global write not all lanes");
   a_burst_capture: assert property (brst |-> data_capture == |core_lane_write)
      else $error("burst capture wrong");
   a_write_quiet: assert property (data_capture |=> !bus_drive_en)
      else $error("bus driven in write");
   a_hold_addr: assert property (cycle_kind == 3'd4 |=> $stable(core_addr))
      else $error("suspend moved address");
   a_step_linear: assert property (cycle_kind == 3'd3 && !burst_order && !$past(burst_order) |=> core_addr[1:0] == $past(core_addr[1:0]) + 2'd1)
      else $error("linear step wrong");
endmodule // sbs_cycle_decode_checker
bind sbs_cycle_decode sbs_cycle_decode_checker #(.LANES(LANES), .ADDR_W(ADDR_W)) u_chk (.*);
`default_nettype wire

// ### bench/tb_top.sv
// self-checking bench for the burst sram cycle decode
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        ref_clk = 1'b0;
   logic        arst_n = 1'b0;
   logic        burst_order = 1'b0;
   logic [19:0] ext_addr = 20'h0_0002;
   logic [13:0] drv = 14'h05ff;
   wire         write_soon, sleep_request, primary_select_n, expansion_select_hi;
   wire         expansion_select_n, processor_addr_strobe_n, controller_addr_strobe_n;
   wire         burst_advance_n, global_write_n, lane_write_enable_n, output_enable_n;
   wire  [3:0]  lane_select_n;
   wire  [19:0] core_addr;
   wire  [2:0]  cycle_kind;
   wire  [3:0]  core_lane_write;
   wire         core_read, data_capture, bus_drive_en, in_sleep;
   int          n_errors = 0;
   int          n_compared = 0;
   // one vector carries every strobe, select, write and lane input, lanes presented at the rise
   assign {write_soon, sleep_request, primary_select_n, expansion_select_hi, expansion_select_n,
           processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n, global_write_n,
           lane_write_enable_n, lane_select_n} = drv;
   always #12.5 ref_clk = ~ref_clk;
   sbs_cycle_decode uut (.*);
   sbs_master_model u_master (.*);
   // results show one call later, bus drive and address two calls later, sampled at the falling edge
   task step(input logic [13:0] v);
      @(posedge ref_clk);
      drv <= v;
      @(negedge ref_clk);
   endtask
   task chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task t_sleep;
      step(14'h0d7f);
      step(14'h15ff);
      chk({5'h00, cycle_kind}, 8'h00);
      step(14'h0dff);
      chk({4'h0, in_sleep, cycle_kind}, 8'h09);
      step(14'h0dff);
      chk({7'h00, bus_drive_en}, 8'h00);
      step(14'h04c0);
      step(14'h05ff);
      chk({4'h0, core_read, cycle_kind}, 8'h0a);
      step(14'h05ff);
      chk({7'h00, bus_drive_en}, 8'h01);
   endtask
   task t_burst;
      step(14'h24c0);
      step(14'h259f);
      chk({cycle_kind, core_read, core_lane_write}, 8'h50);
      step(14'h25e5);
      chk({cycle_kind, data_capture, core_lane_write}, 8'h7f);
      step(14'h25ff);
      chk({cycle_kind, data_capture, core_lane_write}, 8'h9a);
      chk(core_addr[7:0], 8'h03);
   endtask
   // every lane pattern in a controller strobe write, checked one call later
   task t_lanes;
      int i;
      for (i = 0; i < 17; i++) begin
         step({10'h256, i[3:0]});
         if (i > 0) chk({1'b0, cycle_kind, core_lane_write}, {4'h2, ~(i[3:0] - 4'h1)});
      end
   endtask
   // interleaved burst from a high external address
   task t_order;
      @(posedge ref_clk);
      burst_order <= 1'b1;
      ext_addr    <= 20'ha_5003;
      drv         <= 14'h04c0;
      step(14'h05bf);
      step(14'h05bf);
      chk(core_addr[19:12], 8'ha5);
      step(14'h05ff);
      chk(core_addr[7:0], 8'h02);
   endtask
   task complete_run;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge ref_clk);
      arst_n <= 1'b1;
      t_sleep;
      t_burst;
      t_lanes;
      t_order;
      complete_run;
   end
endmodule // tb_top
`default_nettype wire
